// file: rtl/ir_capture_pkg.sv
// Shared constants, types and register map of the infrared edge capture unit
package ir_capture_pkg;

  // Bus widths
  localparam int AXI_ADDR_W = 8; // Byte address width of the register port
  localparam int AXI_DATA_W = 32; // Data width of the register port
  localparam int REG_W = 8; // Width of every register of the unit
  localparam int CAP_W = 16; // Width of the capture counter and captures

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_FLAG_STATUS = 6'h01; // capture_flag_status
  localparam logic [5:0] IDX_TIMER_CONTROL = 6'h02; // capture_timer_control
  localparam logic [5:0] IDX_CAP_LOW = 6'h03; // capture_low_byte
  localparam logic [5:0] IDX_CAP_HIGH = 6'h04; // capture_high_byte
  localparam logic [5:0] IDX_CAP_MODE = 6'h05; // Interval reference select
  localparam logic [5:0] IDX_PRESCALE = 6'h06; // Counter prescaler divisor

  // Field positions in capture_flag_status
  localparam int RISE_BIT = 2; // rising_edge_flag
  localparam int FALL_BIT = 1; // falling_edge_flag
  localparam int TOUT_BIT = 0; // timer_timeout_flag

  // Field positions in capture_timer_control
  localparam int HALT_BIT = 6; // timer_halt
  localparam int EDGE_LSB = 4; // edge_select low bit
  localparam int EDGE_MSB = 5; // edge_select high bit
  localparam int CTRL_RSVD_BIT = 7; // Reserved, reads zero

  // Field position in the mode register
  localparam int MODE_BIT = 0; // 0 since last capture, 1 since overflow

  // Reset values
  localparam logic [7:0] TIMER_CONTROL_RST = 8'h40; // Halted, no edges
  localparam logic [7:0] PRESCALE_RST = 8'h00; // Divide by one
  localparam logic MODE_RST = 1'b0; // Interval since previous capture
  localparam logic [15:0] CAP_RST = 16'h0000; // Cleared capture value

  // edge_select encodings
  localparam logic [1:0] EDGE_NONE = 2'h0; // No capture
  localparam logic [1:0] EDGE_RISE = 2'h1; // Rising edges only
  localparam logic [1:0] EDGE_FALL = 2'h2; // Falling edges only
  localparam logic [1:0] EDGE_BOTH = 2'h3; // Both edges

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0; // Access done
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

  // Events from the input sensing stage
  typedef struct packed {
    logic rise; // Rising edge seen on the infrared input
    logic fall; // Falling edge seen on the infrared input
    logic tick; // Prescaled counting tick
  } edge_evt_t;

  // Write channel states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  // Read channel states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

endpackage

// file: rtl/ir_edge_sense.sv
// Infrared input edge detector and counting prescaler
`timescale 1ns/10ps
module ir_edge_sense #(
  parameter int PRE_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ir_in,
  input wire logic [PRE_W-1:0] prescale,
  output ir_capture_pkg::edge_evt_t events
);
  import ir_capture_pkg::*;

  logic ir_prev_ff; // Input level of the previous cycle
  logic primed_ff; // Set once ir_prev_ff holds a real sample
  logic [PRE_W-1:0] pre_cnt_ff; // Prescaler count
  edge_evt_t events_ff; // Registered event pulses

  // Previous level; no edges until one real sample is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_prev_ff <= 1'b0;
      primed_ff <= 1'b0;
    end else begin
      ir_prev_ff <= ir_in;
      primed_ff <= 1'b1;
    end
  end

  // Prescaler, one tick every prescale+1 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_ff <= '0;
    end else if (pre_cnt_ff >= prescale) begin
      pre_cnt_ff <= '0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 1'b1;
    end
  end

  // Event pulses, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      events_ff <= '0;
    end else begin
      events_ff.rise <= primed_ff & ir_in & ~ir_prev_ff;
      events_ff.fall <= primed_ff & ~ir_in & ir_prev_ff;
      events_ff.tick <= (pre_cnt_ff >= prescale);
    end
  end

  assign events = events_ff;

endmodule

// file: rtl/ir_edge_capture.sv
// Infrared edge capture unit with AXI4-Lite register port
`timescale 1ns/10ps
module ir_edge_capture #(
  parameter int PRE_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Infrared receiver output
  input wire logic ir_in,
  // Interrupt request toward the interrupt controller
  output logic ir_irq,
  // AXI4-Lite write address
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [ir_capture_pkg::AXI_ADDR_W-1:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  // AXI4-Lite write data
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [ir_capture_pkg::AXI_DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // AXI4-Lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // AXI4-Lite read address
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [ir_capture_pkg::AXI_ADDR_W-1:0] s_araddr,
  input wire logic [2:0] s_arprot,
  // AXI4-Lite read data
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [ir_capture_pkg::AXI_DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp
);
  import ir_capture_pkg::*;

  // Address decode shared by the read and write paths
  function automatic logic reg_hit(input logic [AXI_ADDR_W-1:0] addr, input logic [5:0] idx);
    reg_hit = (addr[AXI_ADDR_W-1:2] == idx);
  endfunction

  // True for any mapped register
  function automatic logic reg_mapped(input logic [AXI_ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, IDX_FLAG_STATUS) | reg_hit(addr, IDX_TIMER_CONTROL) |
                 reg_hit(addr, IDX_CAP_LOW) | reg_hit(addr, IDX_CAP_HIGH) |
                 reg_hit(addr, IDX_CAP_MODE) | reg_hit(addr, IDX_PRESCALE);
  endfunction

  // Bus slave state
  wr_state_t wr_state_ff; // Write channel state
  rd_state_t rd_state_ff; // Read channel state
  logic aw_got_ff; // Write address already taken
  logic w_got_ff; // Write data already taken
  logic [AXI_ADDR_W-1:0] aw_addr_ff; // Held write address
  logic [7:0] w_byte_ff; // Held write data, low lane
  logic w_lane0_ff; // Held strobe of the low lane
  logic awready_ff; // Write address ready
  logic wready_ff; // Write data ready
  logic bvalid_ff; // Write response valid
  logic [1:0] bresp_ff; // Write response code
  logic arready_ff; // Read address ready
  logic rvalid_ff; // Read data valid
  logic [AXI_DATA_W-1:0] rdata_ff; // Read data
  logic [1:0] rresp_ff; // Read response code

  // Block state
  logic [7:0] timer_control_ff; // capture_timer_control
  logic cap_mode_ff; // Interval reference select
  logic [PRE_W-1:0] prescale_ff; // Prescaler divisor minus one
  logic rising_edge_flag_ff; // Rising edge captured
  logic falling_edge_flag_ff; // Falling edge captured
  logic timer_timeout_flag_ff; // Counter wrapped
  logic [CAP_W-1:0] cnt_ff; // Capture counter
  logic [CAP_W-1:0] rise_cap_ff; // Capture of the latest rising edge
  logic [CAP_W-1:0] fall_cap_ff; // Capture of the latest falling edge
  logic first_is_rise_ff; // Latest capture taken with no other kind left pending was a rising one
  logic irq_ff; // Interrupt request

  // Combinational helpers
  edge_evt_t evt; // Events from the sensing stage
  logic aw_hs; // Write address handshake
  logic w_hs; // Write data handshake
  logic ar_hs; // Read address handshake
  logic wr_fire; // Write address and data both present
  logic [AXI_ADDR_W-1:0] wr_addr; // Address of the write in progress
  logic [7:0] wr_byte; // Low byte of the write in progress
  logic wr_lane0; // Low lane enabled for the write
  logic wr_lane_ok; // Write touches the register byte
  logic flag_wr; // Write to capture_flag_status
  logic [1:0] edge_select; // Enabled edge kinds
  logic timer_halt; // Counter stopped
  logic cap_rise; // Enabled rising edge capture
  logic cap_fall; // Enabled falling edge capture
  logic cnt_step; // Counter advances this cycle
  logic cnt_wrap; // Counter passes its maximum
  logic nxt_rise_flag; // Next rising flag
  logic nxt_fall_flag; // Next falling flag
  logic nxt_tout_flag; // Next time-out flag
  logic flag_cleared; // A set flag is cleared this cycle
  logic [CAP_W-1:0] shown_cap; // Capture visible to software
  logic [7:0] rd_byte; // Read value of the addressed register
  logic rd_err; // Read of an unmapped address

  // Input edge sensing and prescaler
  ir_edge_sense #(
    .PRE_W(PRE_W)
  ) u_sense (
    .aclk(aclk),
    .aresetn(aresetn),
    .ir_in(ir_in),
    .prescale(prescale_ff),
    .events(evt)
  );

  // Handshakes and the merged write request
  assign aw_hs = s_awvalid & awready_ff;
  assign w_hs = s_wvalid & wready_ff;
  assign ar_hs = s_arvalid & arready_ff;
  assign wr_addr = aw_got_ff ? aw_addr_ff : s_awaddr;
  assign wr_byte = w_got_ff ? w_byte_ff : s_wdata[7:0];
  assign wr_lane0 = w_got_ff ? w_lane0_ff : s_wstrb[0];
  assign wr_fire = (wr_state_ff == WR_IDLE) & (aw_got_ff | aw_hs) & (w_got_ff | w_hs);
  assign wr_lane_ok = wr_fire & wr_lane0;
  assign flag_wr = wr_lane_ok & reg_hit(wr_addr, IDX_FLAG_STATUS);

  // Control fields
  assign edge_select = timer_control_ff[EDGE_MSB:EDGE_LSB];
  assign timer_halt = timer_control_ff[HALT_BIT];

  // Enabled captures per edge kind
  assign cap_rise = evt.rise & ((edge_select == EDGE_RISE) | (edge_select == EDGE_BOTH));
  assign cap_fall = evt.fall & ((edge_select == EDGE_FALL) | (edge_select == EDGE_BOTH));

  // Counter stepping and wrap
  assign cnt_step = evt.tick & ~timer_halt;
  assign cnt_wrap = cnt_step & (cnt_ff == {CAP_W{1'b1}});

  // Flags: a set in the same cycle wins over a write-1 clear
  assign nxt_rise_flag = cap_rise | (rising_edge_flag_ff & ~(flag_wr & wr_byte[RISE_BIT]));
  assign nxt_fall_flag = cap_fall | (falling_edge_flag_ff & ~(flag_wr & wr_byte[FALL_BIT]));
  assign nxt_tout_flag = cnt_wrap | (timer_timeout_flag_ff & ~(flag_wr & wr_byte[TOUT_BIT]));

  // Any pending flag dropped by software this cycle
  assign flag_cleared = (rising_edge_flag_ff & ~nxt_rise_flag) |
                        (falling_edge_flag_ff & ~nxt_fall_flag) |
                        (timer_timeout_flag_ff & ~nxt_tout_flag);

  // Capture shown to software: the only pending one, otherwise the kind first_is_rise_ff names
  always_comb begin
    if (rising_edge_flag_ff & falling_edge_flag_ff) begin
      shown_cap = first_is_rise_ff ? rise_cap_ff : fall_cap_ff;
    end else if (rising_edge_flag_ff) begin
      shown_cap = rise_cap_ff;
    end else if (falling_edge_flag_ff) begin
      shown_cap = fall_cap_ff;
    end else begin
      shown_cap = first_is_rise_ff ? rise_cap_ff : fall_cap_ff;
    end
  end

  // Read value of the addressed register
  always_comb begin
    rd_byte = 8'h00;
    rd_err = 1'b0;
    if (reg_hit(s_araddr, IDX_FLAG_STATUS)) begin
      // Upper bits read zero
      rd_byte[RISE_BIT] = rising_edge_flag_ff;
      rd_byte[FALL_BIT] = falling_edge_flag_ff;
      rd_byte[TOUT_BIT] = timer_timeout_flag_ff;
    end else if (reg_hit(s_araddr, IDX_TIMER_CONTROL)) begin
      rd_byte = timer_control_ff;
    end else if (reg_hit(s_araddr, IDX_CAP_LOW)) begin
      rd_byte = shown_cap[7:0];
    end else if (reg_hit(s_araddr, IDX_CAP_HIGH)) begin
      rd_byte = shown_cap[15:8];
    end else if (reg_hit(s_araddr, IDX_CAP_MODE)) begin
      rd_byte[MODE_BIT] = cap_mode_ff;
    end else if (reg_hit(s_araddr, IDX_PRESCALE)) begin
      rd_byte[PRE_W-1:0] = prescale_ff;
    end else begin
      // Unmapped address
      rd_err = 1'b1;
    end
  end

  // Write channel: address and data in either order, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= WR_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_byte_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      case (wr_state_ff)
        WR_IDLE: begin
          // Hold each half as it arrives
          if (aw_hs) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_awaddr;
          end
          if (w_hs) begin
            w_got_ff <= 1'b1;
            w_byte_ff <= s_wdata[7:0];
            w_lane0_ff <= s_wstrb[0];
          end
          awready_ff <= ~(aw_got_ff | aw_hs);
          wready_ff <= ~(w_got_ff | w_hs);
          // Both halves present: answer
          if (wr_fire) begin
            wr_state_ff <= WR_RESP;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= reg_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          // Wait for the master to take the response
          if (s_bready) begin
            wr_state_ff <= WR_IDLE;
            bvalid_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
          end
        end
        default: begin
          wr_state_ff <= WR_IDLE;
        end
      endcase
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= RD_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      case (rd_state_ff)
        RD_IDLE: begin
          arready_ff <= 1'b1;
          if (ar_hs) begin
            rd_state_ff <= RD_DATA;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_byte};
            rresp_ff <= rd_err ? RESP_SLVERR : RESP_OKAY;
          end
        end
        RD_DATA: begin
          // Hold the data until the master takes it
          if (s_rready) begin
            rd_state_ff <= RD_IDLE;
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
          end
        end
        default: begin
          rd_state_ff <= RD_IDLE;
        end
      endcase
    end
  end

  // Software-written configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_ff <= TIMER_CONTROL_RST;
      cap_mode_ff <= MODE_RST;
      prescale_ff <= PRESCALE_RST[PRE_W-1:0];
    end else if (wr_lane_ok) begin
      if (reg_hit(wr_addr, IDX_TIMER_CONTROL)) begin
        timer_control_ff <= wr_byte;
        timer_control_ff[CTRL_RSVD_BIT] <= 1'b0;
      end
      if (reg_hit(wr_addr, IDX_CAP_MODE)) begin
        cap_mode_ff <= wr_byte[MODE_BIT];
      end
      if (reg_hit(wr_addr, IDX_PRESCALE)) begin
        prescale_ff <= wr_byte[PRE_W-1:0];
      end
    end
  end

  // Status flags, cleared only by software writing ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rising_edge_flag_ff <= 1'b0;
      falling_edge_flag_ff <= 1'b0;
      timer_timeout_flag_ff <= 1'b0;
    end else begin
      rising_edge_flag_ff <= nxt_rise_flag;
      falling_edge_flag_ff <= nxt_fall_flag;
      timer_timeout_flag_ff <= nxt_tout_flag;
    end
  end

  // Capture counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if ((cap_rise | cap_fall) & ~cap_mode_ff) begin
      // Restart so the next capture is the interval since this one
      cnt_ff <= '0;
    end else if (cnt_step) begin
      // Wraps to zero; in overflow mode this is the reference point
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Per-edge captures; a later edge of the same kind overwrites
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_cap_ff <= CAP_RST;
      fall_cap_ff <= CAP_RST;
    end else begin
      if (cap_rise) begin
        rise_cap_ff <= cnt_ff;
      end
      if (cap_fall) begin
        fall_cap_ff <= cnt_ff;
      end
    end
  end

  // Kind of the latest capture made while the other kind is not left pending; held otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_is_rise_ff <= 1'b0;
    end else if (cap_rise & ~(falling_edge_flag_ff & nxt_fall_flag)) begin
      first_is_rise_ff <= 1'b1;
    end else if (cap_fall & ~(rising_edge_flag_ff & nxt_rise_flag)) begin
      first_is_rise_ff <= 1'b0;
    end
  end

  // Interrupt request: high while any flag is set, dropped for one
  // cycle when one is serviced so a still-pending one raises it anew
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (nxt_rise_flag | nxt_fall_flag | nxt_tout_flag) & ~flag_cleared;
    end
  end

  // Outputs, all from flip-flops
  assign ir_irq = irq_ff;
  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

endmodule

// file: dv/ir_capture_assertions.sv
// Checker of bus handshakes and interrupt behaviour at the capture unit ports
`timescale 1ns/10ps
module ir_capture_assertions
  import ir_capture_pkg::*;
#(
  parameter int PRE_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ir_in,
  input wire logic ir_irq,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [1:0] s_bresp,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [7:0] s_araddr,
  input wire logic [2:0] s_arprot,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp
);
  // One clock domain for every check
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  localparam logic [7:0] A_FLAG = {IDX_FLAG_STATUS, 2'b00}; // Flag register
  localparam logic [7:0] A_CTRL = {IDX_TIMER_CONTROL, 2'b00}; // Control register
  wire w_take = s_wvalid && s_wready; // Write data taken
  wire r_take = s_arvalid && s_arready; // Read address taken
  // Bus answers and their holding
  wr_answer_a: assert property (s_awvalid && s_awready && w_take |=> s_bvalid && !s_awready)
    else $error("write answer late");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write answer dropped");
  wr_refuse_a: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while answering");
  rd_answer_a: assert property (r_take |=> s_rvalid && !s_arready)
    else $error("read answer late");
  rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp))
    else $error("read answer changed");
  unmapped_rd_a: assert property (r_take && (s_araddr[7:2] > IDX_PRESCALE || s_araddr[7:2] == 6'h00)
    |=> s_rresp == RESP_SLVERR && s_rdata == 32'h0)
    else $error("unmapped read answered");
  // Reserved bits read zero
  flag_rsvd_a: assert property (r_take && s_araddr == A_FLAG |=> s_rdata[31:3] == 29'h0)
    else $error("flag reserved bits set");
  ctrl_rsvd_a: assert property (r_take && s_araddr == A_CTRL |=> s_rdata[31:7] == 25'h0)
    else $error("control reserved bit set");
  // Request only drops after a software write
  irq_clear_a: assert property ($fell(ir_irq) |-> $past(w_take) || $past(w_take, 2) || $past(w_take, 3))
    else $error("request dropped without a write");
  fall_c: cover property ($fell(ir_irq));
  err_c: cover property (s_rvalid && s_rresp == RESP_SLVERR);
  wr_c: cover property (s_bvalid && s_bready);
endmodule

bind ir_edge_capture ir_capture_assertions #(.PRE_W(PRE_W)) chk_i (
  .aclk, .aresetn, .ir_in, .ir_irq, .s_awvalid, .s_awready, .s_awaddr, .s_awprot,
  .s_wvalid, .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp,
  .s_arvalid, .s_arready, .s_araddr, .s_arprot, .s_rvalid, .s_rready, .s_rdata, .s_rresp
);

// file: dv/ir_receiver_model.sv
// Infrared receiver model driving the demodulated output level
`timescale 1ns/10ps
module ir_receiver_model (
  input wire logic aclk,
  input wire logic level,
  output logic ir_in
);
  // Receiver output idles high between bursts
  initial ir_in = 1'b1;
  // Output follows the requested level one clock later
  always @(posedge aclk) begin
    ir_in <= level;
  end
endmodule

// file: dv/tb.sv
// Self-checking bench of the infrared edge capture unit
`timescale 1ns/10ps
module tb;
  import ir_capture_pkg::*;
  localparam logic [7:0] A_FLAG = {IDX_FLAG_STATUS, 2'b00}; // Flag register
  localparam logic [7:0] A_CTRL = {IDX_TIMER_CONTROL, 2'b00}; // Control register
  localparam logic [7:0] A_LO = {IDX_CAP_LOW, 2'b00}; // Capture low byte
  localparam logic [7:0] A_HI = {IDX_CAP_HIGH, 2'b00}; // Capture high byte
  localparam logic [7:0] A_MODE = {IDX_CAP_MODE, 2'b00}; // Reference select
  localparam logic [7:0] A_PRE = {IDX_PRESCALE, 2'b00}; // Prescaler
  logic aclk, aresetn, ir_level, ir_in, ir_irq;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [AXI_ADDR_W-1:0] s_awaddr, s_araddr;
  logic [AXI_DATA_W-1:0] s_wdata, s_rdata;
  logic [1:0] s_bresp, s_rresp;
  int err_total, total_checks, cyc_cnt;
  logic [7:0] rd; // Last read byte
  logic [1:0] rs; // Last read response
  // Clock and free cycle count
  always #4 aclk = ~aclk;
  always @(posedge aclk) cyc_cnt <= cyc_cnt + 1;
  ir_edge_capture dut (
    .aclk(aclk), .aresetn(aresetn), .ir_in(ir_in), .ir_irq(ir_irq),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr), .s_awprot(3'h0),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(4'hF),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr), .s_arprot(3'h0),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp)
  );
  ir_receiver_model rx (.aclk(aclk), .level(ir_level), .ir_in(ir_in));
  // Counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic guard(input bit bad);
    if (bad) begin
      err_total++;
      $display("wait ran out");
      print_verdict();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write with response check
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_awvalid <= 1'b1;
    s_awaddr <= a;
    s_wvalid <= 1'b1;
    s_wdata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while ((s_awvalid || s_wvalid) && n < 50);
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_bvalid !== 1'b1 && n < 50);
    s_bready <= 1'b0;
    guard(n >= 50);
    chk("write response", {30'h0, er}, {30'h0, s_bresp});
  endtask
  // Bus read
  task automatic rdr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_arvalid <= 1'b1;
    s_araddr <= a;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_arready !== 1'b1 && n < 50);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_rvalid !== 1'b1 && n < 50);
    s_rready <= 1'b0;
    guard(n >= 50);
    d = s_rdata[7:0];
    r = s_rresp;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    rdr(a, rd, rs);
    chk(nm, {24'h0, e}, {24'h0, rd});
    chk("read response", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask
  task automatic ir_set(input logic lvl, output int t);
    @(posedge aclk);
    ir_level <= lvl;
    t = cyc_cnt;
  endtask
  // Low pulse ending in a rising edge, then capture read
  task automatic hit(input bit clr, output int t, output logic [15:0] c);
    int u;
    ir_set(1'b0, u);
    cyc(8);
    ir_set(1'b1, t);
    cyc(8);
    rchk("flag pending", A_FLAG, 8'h04);
    rdr(A_LO, rd, rs);
    c[7:0] = rd;
    rdr(A_HI, rd, rs);
    c[15:8] = rd;
    if (clr) wr(A_FLAG, 8'h04, RESP_OKAY);
  endtask
  task automatic s_reset();
    rchk("flags", A_FLAG, 8'h00);
    rchk("control", A_CTRL, TIMER_CONTROL_RST);
    rchk("cap low", A_LO, CAP_RST[7:0]);
    rchk("cap high", A_HI, CAP_RST[15:8]);
    rchk("mode", A_MODE, {7'h0, MODE_RST});
    rchk("prescale", A_PRE, PRESCALE_RST);
    rdr(8'h3C, rd, rs);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(8'h3C, 8'hFF, RESP_SLVERR);
    wr(A_CTRL, 8'hFF, RESP_OKAY);
    rchk("control top bit", A_CTRL, 8'h7F);
  endtask
  // Every edge selection, halted counter
  task automatic s_edges();
    int t;
    for (int k = 0; k < 4; k++) begin
      wr(A_CTRL, {2'b01, 2'(k), 4'h0}, RESP_OKAY);
      wr(A_FLAG, 8'h07, RESP_OKAY);
      ir_set(1'b0, t);
      cyc(8);
      ir_set(1'b1, t);
      cyc(8);
      rchk("edge flags", A_FLAG, {5'h0, k[0], k[1], 1'b0});
      chk("request", {31'h0, k != 0}, {31'h0, ir_irq});
    end
    wr(A_FLAG, 8'h07, RESP_OKAY);
  endtask
  // Both polarities pending, cleared one at a time
  task automatic s_pending();
    int t;
    wr(A_CTRL, 8'h70, RESP_OKAY);
    ir_set(1'b0, t);
    cyc(8);
    ir_set(1'b1, t);
    cyc(8);
    wr(A_FLAG, 8'h00, RESP_OKAY);
    rchk("both pending", A_FLAG, 8'h06);
    wr(A_FLAG, 8'h04, RESP_OKAY);
    cyc(3);
    chk("request again", 32'h1, {31'h0, ir_irq});
    rchk("falling kept", A_FLAG, 8'h02);
    wr(A_FLAG, 8'h02, RESP_OKAY);
    cyc(3);
    chk("request off", 32'h0, {31'h0, ir_irq});
  endtask
  task automatic s_mode1();
    int t1, t2;
    logic [15:0] c1, c2;
    wr(A_MODE, 8'h01, RESP_OKAY);
    wr(A_CTRL, 8'h10, RESP_OKAY);
    hit(1'b1, t1, c1);
    cyc(300);
    hit(1'b1, t2, c2);
    chk("free interval", {16'h0, 16'(t2 - t1)}, {16'h0, c2 - c1});
  endtask
  task automatic s_halt();
    int t1, t2;
    logic [15:0] c1, c2;
    wr(A_CTRL, 8'h50, RESP_OKAY);
    hit(1'b1, t1, c1);
    cyc(300);
    hit(1'b1, t2, c2);
    chk("halted count", {16'h0, c1}, {16'h0, c2});
  endtask
  // Pending capture overwritten, interval since last capture
  task automatic s_mode0();
    int t0, t1, t2;
    logic [15:0] c0, c1, c2;
    wr(A_MODE, 8'h00, RESP_OKAY);
    wr(A_CTRL, 8'h10, RESP_OKAY);
    hit(1'b1, t0, c0);
    cyc(200);
    hit(1'b0, t1, c1);
    cyc(500);
    hit(1'b1, t2, c2);
    chk("interval change", {16'h0, 16'((t2 - t1) - (t1 - t0))}, {16'h0, c2 - c1});
  endtask
  task automatic s_prescale();
    int t1, t2, d;
    logic [15:0] c1, c2;
    wr(A_PRE, 8'h03, RESP_OKAY);
    wr(A_MODE, 8'h01, RESP_OKAY);
    hit(1'b1, t1, c1);
    cyc(400);
    hit(1'b1, t2, c2);
    d = 4 * int'(c2 - c1) - (t2 - t1);
    chk("prescaled interval", 32'h1, {31'h0, d > -4 && d < 4});
  endtask
  // Counter wrap from a fresh restart
  task automatic s_timeout();
    int t0, n;
    logic [15:0] c0;
    wr(A_PRE, 8'h00, RESP_OKAY);
    wr(A_MODE, 8'h00, RESP_OKAY);
    hit(1'b1, t0, c0);
    n = 0;
    while (ir_irq !== 1'b1 && n < 70000) begin
      @(posedge aclk);
      n++;
    end
    guard(n >= 70000);
    chk("wrap time", 32'h1, {31'h0, cyc_cnt - t0 >= 65530 && cyc_cnt - t0 <= 65560});
    wr(A_FLAG, 8'h06, RESP_OKAY);
    rchk("timeout flag", A_FLAG, 8'h01);
    wr(A_FLAG, 8'h01, RESP_OKAY);
    rchk("timeout cleared", A_FLAG, 8'h00);
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ir_level = 1'b1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    err_total = 0;
    total_checks = 0;
    cyc_cnt = 0;
    cyc(12);
    aresetn <= 1'b1;
    cyc(2);
    s_reset();
    s_edges();
    s_pending();
    s_mode1();
    s_halt();
    s_mode0();
    s_prescale();
    s_timeout();
    print_verdict();
  end
endmodule
